// file: hw/qsds_top.sv
// Quick stop and shutdown deceleration sequencer of the drive
`timescale 1ns/100ps
// Notes on behaviour
// - Homing, code 7: stop at maximum deceleration, then stay quick stop active.
// - Torque modes: ramp torque at torque slope for codes 1 to 3 and 5 to 7, end state set by code.
// - Codes -1 and -2 are reserved; they start no user stop sequence.
// - Control word bit 2 falling from 1 to 0 starts the deceleration.
// - While the quick stop ramp runs, report quick stop active.
// - Motor counts as stopped at actual speed of 30 r/min or less.
// - After standstill enter switch-on-disabled or quick-stop-active per code.
// - Shutdown option code picks the stop method for shutdown or disable voltage.
// - Undefined quick stop codes are disabled and select no sequence.
// - Position and velocity modes, code 2: quick stop rate then switch-on-disabled.
module qsds_top
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic [15:0] ctrl_word_in,
   input wire logic [7:0] op_mode_in,
   input wire logic signed [31:0] actual_speed_in,
   input wire logic signed [31:0] cmd_value_in,
   input wire logic [15:0] obj_index_in,
   input wire logic obj_wr_in,
   input wire logic obj_rd_in,
   input wire logic [31:0] obj_wdata_in,
   output logic [31:0] obj_rdata_out,
   output logic obj_ack_out,
   output logic signed [31:0] cmd_value_out,
   output logic [2:0] pds_state_out,
   output logic stopped_out
);
   import qsds_pkg::*;

   typedef struct packed {
      qsds_state_type st;
      logic cw_qs_prev;
      logic cw_ev_prev;
      logic [2:0] cw_low_prev;
      logic [15:0] servo_off_stop_sequence;
      logic [15:0] qs_option;
      logic [15:0] sd_option;
      logic [31:0] profile_decel_rate;
      logic [31:0] quick_stop_decel_rate;
      logic [31:0] torque_ramp_rate;
      logic [31:0] homing_accel_rate;
      logic [31:0] max_decel_rate;
      logic [31:0] rate;
      qsds_state_type end_st;
      logic neg;
      logic qs_ramp;
      logic [31:0] rdata;
      logic ack;
      logic [2:0] pds;
      logic stopped;
   } qsds_top_type;

   qsds_top_type s_reg;
   qsds_top_type s_next;
   logic [31:0] ramp_value;
   logic ramp_load;
   logic [31:0] cmd_mag;
   logic [31:0] spd_mag;
   logic qs_fall;
   logic sd_cmd;
   logic dv_cmd;
   logic is_torque;
   logic is_homing;
   logic is_posvel;
   logic sel_ok;
   logic [31:0] sel_rate;
   qsds_state_type sel_end;
   logic at_standstill;
   logic [31:0] ramp_start;

   assign cmd_mag = cmd_value_in[31] ? 32'(-cmd_value_in) : cmd_value_in;
   assign spd_mag = actual_speed_in[31] ? 32'(-actual_speed_in) : actual_speed_in;
   assign at_standstill = spd_mag <= STANDSTILL_RPM;
   assign is_torque = (op_mode_in == MODE_TQ) || (op_mode_in == MODE_CST);
   assign is_homing = op_mode_in == MODE_HM;
   assign is_posvel = (op_mode_in == MODE_PP) || (op_mode_in == MODE_PV)
      || (op_mode_in == MODE_IP) || (op_mode_in == MODE_CSP) || (op_mode_in == MODE_CSV);
   assign qs_fall = s_reg.cw_qs_prev && !ctrl_word_in[CW_QS_BIT];
   assign sd_cmd = (ctrl_word_in[2:0] == CW_SHUTDOWN) && (s_reg.cw_low_prev != CW_SHUTDOWN);
   assign dv_cmd = s_reg.cw_ev_prev && !ctrl_word_in[CW_EV_BIT];
   // Start one step down so the output already falls on the first ramp cycle
   assign ramp_start = (cmd_mag > sel_rate) ? cmd_mag - sel_rate : 32'h0000_0000;

   // ***************************************************
   // Stop profile selection
   // ***************************************************
   always_comb
   begin
      logic [31:0] servo_rate;
      logic [31:0] slow_rate;
      servo_rate = (s_reg.servo_off_stop_sequence == 16'h0000) ? RATE_IMMEDIATE
         : s_reg.max_decel_rate;
      slow_rate = is_torque ? s_reg.torque_ramp_rate
         : is_homing ? s_reg.homing_accel_rate : s_reg.profile_decel_rate;
      sel_ok = 1'b0;
      sel_rate = servo_rate;
      sel_end = QSDS_SW_ON_DIS;
      if (qs_fall)
      begin
         // Negative codes, including the reserved -1 and -2, stay disabled
         if (is_torque)
         begin
            case (s_reg.qs_option)
               16'h0000: begin sel_ok = 1'b1; end
               16'h0001, 16'h0002, 16'h0003: begin sel_ok = 1'b1; sel_rate = slow_rate; end
               16'h0005, 16'h0006, 16'h0007:
               begin
                  sel_ok = 1'b1;
                  sel_rate = slow_rate;
                  sel_end = QSDS_QS_ACTIVE;
               end
               default: sel_ok = 1'b0;
            endcase
         end
         else if (is_homing || is_posvel)
         begin
            case (s_reg.qs_option)
               16'h0000: begin sel_ok = 1'b1; end
               16'h0001, 16'h0005: begin sel_ok = 1'b1; sel_rate = slow_rate; end
               16'h0002, 16'h0006:
               begin
                  sel_ok = 1'b1;
                  sel_rate = s_reg.quick_stop_decel_rate;
               end
               16'h0003, 16'h0007: begin sel_ok = 1'b1; sel_rate = s_reg.max_decel_rate; end
               default: sel_ok = 1'b0;
            endcase
            if (s_reg.qs_option == 16'h0005 || s_reg.qs_option == 16'h0006
               || s_reg.qs_option == 16'h0007)
            begin
               sel_end = QSDS_QS_ACTIVE;
            end
         end
      end
      else if (sd_cmd || dv_cmd)
      begin
         sel_ok = (s_reg.sd_option == 16'h0000) || (s_reg.sd_option == 16'h0001);
         if (s_reg.sd_option == 16'h0001)
         begin
            sel_rate = slow_rate;
         end
         sel_end = dv_cmd ? QSDS_SW_ON_DIS : QSDS_READY;
      end
   end

   // ***************************************************
   // Sequencer and object access
   // ***************************************************
   always_comb
   begin
      s_next = s_reg;
      s_next.cw_qs_prev = ctrl_word_in[CW_QS_BIT];
      s_next.cw_ev_prev = ctrl_word_in[CW_EV_BIT];
      s_next.cw_low_prev = ctrl_word_in[2:0];
      s_next.ack = obj_wr_in || obj_rd_in;
      ramp_load = 1'b0;
      if (obj_wr_in)
      begin
         if (obj_index_in == IDX_SERVO_OFF_SEQ)
            s_next.servo_off_stop_sequence = obj_wdata_in[15:0];
         else if (obj_index_in == IDX_QS_OPTION)
            s_next.qs_option = obj_wdata_in[15:0];
         else if (obj_index_in == IDX_SD_OPTION)
            s_next.sd_option = obj_wdata_in[15:0];
         else if (obj_index_in == IDX_PROFILE_DECEL)
            s_next.profile_decel_rate = obj_wdata_in;
         else if (obj_index_in == IDX_QS_DECEL)
            s_next.quick_stop_decel_rate = obj_wdata_in;
         else if (obj_index_in == IDX_TORQUE_RAMP)
            s_next.torque_ramp_rate = obj_wdata_in;
         else if (obj_index_in == IDX_HOMING_ACCEL)
            s_next.homing_accel_rate = obj_wdata_in;
         else if (obj_index_in == IDX_MAX_DECEL)
            s_next.max_decel_rate = obj_wdata_in;
      end
      if (!obj_rd_in)
         s_next.rdata = 32'h0000_0000;
      else if (obj_index_in == IDX_SERVO_OFF_SEQ)
         s_next.rdata = {16'h0000, s_reg.servo_off_stop_sequence};
      else if (obj_index_in == IDX_QS_OPTION)
         s_next.rdata = {16'h0000, s_reg.qs_option};
      else if (obj_index_in == IDX_SD_OPTION)
         s_next.rdata = {16'h0000, s_reg.sd_option};
      else if (obj_index_in == IDX_PROFILE_DECEL)
         s_next.rdata = s_reg.profile_decel_rate;
      else if (obj_index_in == IDX_QS_DECEL)
         s_next.rdata = s_reg.quick_stop_decel_rate;
      else if (obj_index_in == IDX_TORQUE_RAMP)
         s_next.rdata = s_reg.torque_ramp_rate;
      else if (obj_index_in == IDX_HOMING_ACCEL)
         s_next.rdata = s_reg.homing_accel_rate;
      else if (obj_index_in == IDX_MAX_DECEL)
         s_next.rdata = s_reg.max_decel_rate;
      else
         s_next.rdata = 32'h0000_0000;
      case (s_reg.st)
         QSDS_OPERATE:
         begin
            if (sel_ok)
            begin
               ramp_load = 1'b1;
               s_next.rate = sel_rate;
               s_next.end_st = sel_end;
               s_next.neg = cmd_value_in[31];
               s_next.qs_ramp = qs_fall;
               s_next.st = QSDS_DECEL;
            end
         end
         QSDS_DECEL:
         begin
            if (at_standstill)
            begin
               s_next.st = s_reg.end_st;
            end
         end
         QSDS_QS_ACTIVE:
         begin
            if (ctrl_word_in[CW_QS_BIT] && ctrl_word_in[3:0] == CW_ENABLE_OP)
               s_next.st = QSDS_OPERATE;
            else if (!ctrl_word_in[CW_EV_BIT])
               s_next.st = QSDS_SW_ON_DIS;
         end
         default:
         begin
            // Re-enabling is the master's job; a plain enable word resumes operation
            if (ctrl_word_in[3:0] == CW_ENABLE_OP)
               s_next.st = QSDS_OPERATE;
         end
      endcase
      case (s_next.st)
         QSDS_OPERATE: s_next.pds = PDS_OP_EN;
         QSDS_DECEL: s_next.pds = s_next.qs_ramp ? PDS_QS_ACTIVE : PDS_OP_EN;
         QSDS_QS_ACTIVE: s_next.pds = PDS_QS_ACTIVE;
         QSDS_READY: s_next.pds = PDS_READY;
         default: s_next.pds = PDS_SW_ON_DIS;
      endcase
      s_next.stopped = (s_next.st != QSDS_OPERATE) && (s_next.st != QSDS_DECEL);
   end

   qsds_ramp u_ramp
   (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .load_in(ramp_load),
      .load_value_in(ramp_start),
      .step_in(s_reg.st == QSDS_DECEL),
      .rate_in(s_reg.rate),
      .value_out(ramp_value)
   );

   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         s_reg <= '{st: QSDS_OPERATE, end_st: QSDS_SW_ON_DIS, pds: PDS_OP_EN,
            qs_option: RST_OPTION, sd_option: RST_OPTION,
            servo_off_stop_sequence: RST_OPTION, profile_decel_rate: RST_RATE,
            quick_stop_decel_rate: RST_RATE, torque_ramp_rate: RST_RATE,
            homing_accel_rate: RST_RATE, max_decel_rate: RST_RATE, rate: RST_RATE,
            default: '0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Pass-through while operating, ramped magnitude with held sign while decelerating, zero once stopped
   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
         cmd_value_out <= 32'h0000_0000;
      else if (s_next.st == QSDS_OPERATE)
         cmd_value_out <= cmd_value_in;
      else if (ramp_load)
         cmd_value_out <= cmd_value_in;
      else if (s_next.st == QSDS_DECEL)
         cmd_value_out <= s_reg.neg ? 32'(-ramp_value) : ramp_value;
      else
         cmd_value_out <= 32'h0000_0000;
   end

   assign obj_rdata_out = s_reg.rdata;
   assign obj_ack_out = s_reg.ack;
   assign pds_state_out = s_reg.pds;
   assign stopped_out = s_reg.stopped;

   // ***************************************************
   // Checks
   // ***************************************************
   sequence qs_request;
      s_reg.st == QSDS_OPERATE && qs_fall && sel_ok;
   endsequence
   sequence qs_enter_decel;
      ##1 s_reg.st == QSDS_DECEL;
   endsequence
   chk_qs_starts_decel: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in) qs_request |-> qs_enter_decel)
      else $error("Quick stop did not start ramp");
   chk_reserved_ignored: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (qs_fall && (s_reg.qs_option == 16'hffff || s_reg.qs_option == 16'hfffe)) |-> !sel_ok)
      else $error("Reserved code started a stop");
   chk_undefined_off: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (qs_fall && s_reg.qs_option > 16'h0007) |-> !sel_ok)
      else $error("Undefined code started a stop");
   chk_homing_code7: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (qs_fall && is_homing && s_reg.qs_option == 16'h0007 && s_reg.st == QSDS_OPERATE)
      |=> s_reg.rate == $past(s_reg.max_decel_rate) && s_reg.end_st == QSDS_QS_ACTIVE)
      else $error("Homing code 7 profile wrong");
   chk_posvel_code2: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (qs_fall && is_posvel && s_reg.qs_option == 16'h0002 && s_reg.st == QSDS_OPERATE)
      |=> s_reg.rate == $past(s_reg.quick_stop_decel_rate) && s_reg.end_st == QSDS_SW_ON_DIS)
      else $error("Code 2 profile wrong");
   chk_torque_slope: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (qs_fall && is_torque && s_reg.st == QSDS_OPERATE && s_reg.qs_option inside {16'h0001,
      16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0007})
      |=> s_reg.rate == $past(s_reg.torque_ramp_rate))
      else $error("Torque slope unused");
   chk_standstill_exit: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (s_reg.st == QSDS_DECEL && at_standstill)
      |=> s_reg.st == $past(s_reg.end_st) && stopped_out)
      else $error("Standstill not ending ramp");
   chk_decel_reports_qsa: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (qs_request ##1 s_reg.st == QSDS_DECEL) |-> pds_state_out == PDS_QS_ACTIVE)
      else $error("Ramp not reported as quick stop active");
   chk_shutdown_ready: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (s_reg.st == QSDS_OPERATE && !qs_fall && sd_cmd && !dv_cmd && s_reg.sd_option == 16'h0001)
      |=> s_reg.end_st == QSDS_READY)
      else $error("Shutdown end state wrong");
   chk_ramp_steps: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      (s_reg.st == QSDS_DECEL && $past(s_reg.st) == QSDS_DECEL && ramp_value > s_reg.rate)
      |=> ramp_value == $past(ramp_value) - $past(s_reg.rate))
      else $error("Ramp step wrong");
endmodule

// file: hw/qsds_pkg.sv
// Constants shared by the quick stop deceleration sequencer
package qsds_pkg;
   // ***************************************************
   // Object dictionary indexes
   // ***************************************************
   localparam logic [15:0] IDX_SERVO_OFF_SEQ = 16'h3506;
   localparam logic [15:0] IDX_QS_OPTION = 16'h605a;
   localparam logic [15:0] IDX_SD_OPTION = 16'h605b;
   localparam logic [15:0] IDX_PROFILE_DECEL = 16'h6084;
   localparam logic [15:0] IDX_QS_DECEL = 16'h6085;
   localparam logic [15:0] IDX_TORQUE_RAMP = 16'h6087;
   localparam logic [15:0] IDX_HOMING_ACCEL = 16'h609a;
   localparam logic [15:0] IDX_MAX_DECEL = 16'h60c6;
   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [15:0] RST_OPTION = 16'h0000;
   localparam logic [31:0] RST_RATE = 32'h0000_0000;
   // ***************************************************
   // Control word fields
   // ***************************************************
   localparam int CW_QS_BIT = 2;
   localparam int CW_EV_BIT = 1;
   localparam logic [3:0] CW_ENABLE_OP = 4'hf;
   localparam logic [2:0] CW_SHUTDOWN = 3'h6;
   // ***************************************************
   // Operation modes
   // ***************************************************
   localparam logic [7:0] MODE_PP = 8'h01;
   localparam logic [7:0] MODE_PV = 8'h03;
   localparam logic [7:0] MODE_TQ = 8'h04;
   localparam logic [7:0] MODE_HM = 8'h06;
   localparam logic [7:0] MODE_IP = 8'h07;
   localparam logic [7:0] MODE_CSP = 8'h08;
   localparam logic [7:0] MODE_CSV = 8'h09;
   localparam logic [7:0] MODE_CST = 8'h0a;
   // ***************************************************
   // Reported drive states and standstill threshold
   // ***************************************************
   localparam logic [2:0] PDS_SW_ON_DIS = 3'h0;
   localparam logic [2:0] PDS_READY = 3'h1;
   localparam logic [2:0] PDS_OP_EN = 3'h2;
   localparam logic [2:0] PDS_QS_ACTIVE = 3'h3;
   localparam logic [31:0] STANDSTILL_RPM = 32'h0000_001e;
   localparam logic [31:0] RATE_IMMEDIATE = 32'hffff_ffff;
   typedef enum logic [2:0] {
      QSDS_OPERATE,
      QSDS_DECEL,
      QSDS_QS_ACTIVE,
      QSDS_SW_ON_DIS,
      QSDS_READY
   } qsds_state_type;
endpackage

// file: hw/qsds_ramp.sv
// Magnitude ramp that steps a value down to zero by a rate each cycle
`timescale 1ns/100ps
module qsds_ramp
(
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic load_in,
   input wire logic [31:0] load_value_in,
   input wire logic step_in,
   input wire logic [31:0] rate_in,
   output logic [31:0] value_out
);
   import qsds_pkg::*;

   typedef struct packed {
      logic [31:0] value;
   } qsds_ramp_type;

   qsds_ramp_type ramp_reg;
   qsds_ramp_type ramp_next;

   always_comb
   begin
      ramp_next = ramp_reg;
      if (load_in)
      begin
         ramp_next.value = load_value_in;
      end
      else if (step_in)
      begin
         // Saturate at zero rather than wrap on the last step
         if (ramp_reg.value > rate_in)
         begin
            ramp_next.value = ramp_reg.value - rate_in;
         end
         else
         begin
            ramp_next.value = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!resetn_in)
      begin
         ramp_reg <= '0;
      end
      else
      begin
         ramp_reg <= ramp_next;
      end
   end

   assign value_out = ramp_reg.value;

   chk_ramp_never_rises: assert property
      (@(posedge clk_sys_in) disable iff (!resetn_in)
      !$past(load_in) |-> value_out <= $past(value_out))
      else $error("Ramp value rose without a load");
endmodule

// file: testbench/qsds_master_model.sv
// Fieldbus master model driving the control word and object accesses
`timescale 1ns/100ps
module qsds_master_model
(
   input wire logic clk_sys_in,
   input wire logic [31:0] obj_rdata_in,
   input wire logic obj_ack_in,
   output logic [15:0] ctrl_word_out,
   output logic [7:0] op_mode_out,
   output logic [15:0] obj_index_out,
   output logic obj_wr_out,
   output logic obj_rd_out,
   output logic [31:0] obj_wdata_out
);
   import qsds_pkg::*;
   initial
   begin
      ctrl_word_out = 16'h0000;
      op_mode_out = MODE_PV;
      obj_index_out = 16'h0000;
      obj_wr_out = 1'b0;
      obj_rd_out = 1'b0;
      obj_wdata_out = 32'h0000_0000;
   end
   // Control word is a level; a quick stop request is bit 2 going from 1 to 0
   task automatic set_cw(input logic [15:0] cw);
      @(posedge clk_sys_in);
      ctrl_word_out <= cw;
   endtask
   task automatic set_mode(input logic [7:0] m);
      @(posedge clk_sys_in);
      op_mode_out <= m;
   endtask
   // One-cycle strobe; the answer is taken at the edge where the ack stands
   task automatic access(input logic wr, input logic rd, input logic [15:0] idx,
         input logic [31:0] wd, output logic [31:0] rdata, output logic ack);
      @(posedge clk_sys_in);
      obj_index_out <= idx;
      obj_wdata_out <= wd;
      obj_wr_out <= wr;
      obj_rd_out <= rd;
      @(posedge clk_sys_in);
      obj_wr_out <= 1'b0;
      obj_rd_out <= 1'b0;
      // Released data lines show the inverse so stale values cannot pass
      obj_wdata_out <= ~wd;
      @(posedge clk_sys_in);
      ack = obj_ack_in;
      rdata = obj_rdata_in;
   endtask
endmodule

// file: testbench/qsds_tb_top.sv
// Self-checking bench of the quick stop deceleration sequencer
`timescale 1ns/100ps
module qsds_tb_top;
   import qsds_pkg::*;
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   logic signed [31:0] actual_speed_in = 32'sh0000_0400;
   logic signed [31:0] cmd_value_in = 32'sh0000_0000;
   logic [15:0] ctrl_word_in;
   logic [7:0] op_mode_in;
   logic [15:0] obj_index_in;
   logic obj_wr_in;
   logic obj_rd_in;
   logic [31:0] obj_wdata_in;
   logic [31:0] obj_rdata_out;
   logic obj_ack_out;
   logic signed [31:0] cmd_value_out;
   logic [2:0] pds_state_out;
   logic stopped_out;
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 32'he0be256b;
   logic [31:0] rate_val [6];
   logic [31:0] rd;
   logic ack;
   localparam logic [15:0] IDX_TAB [8] = '{IDX_SERVO_OFF_SEQ, IDX_PROFILE_DECEL, IDX_QS_DECEL,
      IDX_TORQUE_RAMP, IDX_HOMING_ACCEL, IDX_MAX_DECEL, IDX_QS_OPTION, IDX_SD_OPTION};
   localparam logic [7:0] V_MODE [8] = '{MODE_PV, MODE_HM, MODE_CST, MODE_PP, MODE_CSP,
      MODE_TQ, MODE_CSV, MODE_HM};
   localparam logic [15:0] V_CODE [8] = '{16'h0002, 16'h0007, 16'h0005, 16'h0001, 16'h0006,
      16'h0003, 16'h0007, 16'h0001};
   localparam logic [7:0] X_MODE [4] = '{MODE_TQ, MODE_CST, MODE_PV, MODE_HM};
   localparam logic [15:0] X_CODE [4] = '{16'hffff, 16'hfffe, 16'h0004, 16'h0008};

   always #5 clk_sys_in = ~clk_sys_in;

   qsds_top uut
   (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .ctrl_word_in(ctrl_word_in),
      .op_mode_in(op_mode_in),
      .actual_speed_in(actual_speed_in),
      .cmd_value_in(cmd_value_in),
      .obj_index_in(obj_index_in),
      .obj_wr_in(obj_wr_in),
      .obj_rd_in(obj_rd_in),
      .obj_wdata_in(obj_wdata_in),
      .obj_rdata_out(obj_rdata_out),
      .obj_ack_out(obj_ack_out),
      .cmd_value_out(cmd_value_out),
      .pds_state_out(pds_state_out),
      .stopped_out(stopped_out)
   );

   qsds_master_model master
   (
      .clk_sys_in(clk_sys_in),
      .obj_rdata_in(obj_rdata_out),
      .obj_ack_in(obj_ack_out),
      .ctrl_word_out(ctrl_word_in),
      .op_mode_out(op_mode_in),
      .obj_index_out(obj_index_in),
      .obj_wr_out(obj_wr_in),
      .obj_rd_out(obj_rd_in),
      .obj_wdata_out(obj_wdata_in)
   );

   // ***************************************************
   // Checking and expectations
   // ***************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [31:0] sel_rate(input logic [7:0] m, input logic [15:0] c,
         input logic [1:0] sd);
      if (m == MODE_TQ || m == MODE_CST)
         return rate_val[3];
      if (sd || c == 16'h0001 || c == 16'h0005)
         return (m == MODE_HM) ? rate_val[4] : rate_val[1];
      if (c == 16'h0002 || c == 16'h0006)
         return rate_val[2];
      return rate_val[5];
   endfunction

   function automatic logic [2:0] end_state(input logic [15:0] c, input logic [1:0] sd);
      if (sd == 2'd2)
         return PDS_SW_ON_DIS;
      if (sd != 2'd0)
         return PDS_READY;
      return (c >= 16'h0005) ? PDS_QS_ACTIVE : PDS_SW_ON_DIS;
   endfunction

   // One stop request from operation; invalid codes must leave the ports untouched
   // Kind sd: 0 quick stop, 1 shutdown, 2 disable voltage
   task automatic run_stop(input logic [7:0] m, input logic [15:0] c, input logic [1:0] sd,
         input bit v);
      logic [31:0] mag;
      logic [31:0] dec;
      logic signed [31:0] cv;
      logic signed [31:0] lim;
      int k;
      mag = 32'h0000_1000 + ($random(seed) & 32'h0000_ffff);
      cv = ($random(seed) % 2) ? -$signed(mag) : $signed(mag);
      lim = (cv < 0) ? -32'sd30 : 32'sd30;
      master.access(1'b1, 1'b0, sd ? IDX_SD_OPTION : IDX_QS_OPTION, {16'h0000, c}, rd, ack);
      @(posedge clk_sys_in);
      actual_speed_in <= 32'sh0000_0400;
      cmd_value_in <= cv;
      master.set_mode(m);
      master.set_cw(16'h000f);
      repeat (3) @(posedge clk_sys_in);
      #1;
      check(pds_state_out, PDS_OP_EN);
      check(stopped_out, 1'b0);
      check(cmd_value_out, cv);
      master.set_cw((sd == 2'd2) ? 16'h000d : sd ? 16'h0006 : 16'h000b);
      @(posedge clk_sys_in);
      #1;
      if (!v)
      begin
         check(pds_state_out, PDS_OP_EN);
         check(cmd_value_out, cv);
         return;
      end
      check(pds_state_out, sd ? PDS_OP_EN : PDS_QS_ACTIVE);
      check(cmd_value_out, cv);
      @(posedge clk_sys_in);
      #1;
      dec = mag - sel_rate(m, c, sd);
      check(cmd_value_out, (cv < 0) ? -dec : dec);
      @(posedge clk_sys_in);
      actual_speed_in <= lim + ((cv < 0) ? -32'sd1 : 32'sd1);
      repeat (3) @(posedge clk_sys_in);
      #1;
      check(stopped_out, 1'b0);
      check(pds_state_out, sd ? PDS_OP_EN : PDS_QS_ACTIVE);
      @(posedge clk_sys_in);
      actual_speed_in <= lim;
      for (k = 0; k < 4 && stopped_out !== 1'b1; k++)
      begin
         @(posedge clk_sys_in);
         #1;
      end
      check(stopped_out, 1'b1);
      check(pds_state_out, end_state(c, sd));
      check(cmd_value_out, 32'h0000_0000);
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial
   begin
      repeat (12) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      foreach (IDX_TAB[i])
      begin
         master.access(1'b0, 1'b1, IDX_TAB[i], 32'h0000_0000, rd, ack);
         check(ack, 1'b1);
         check(rd, RST_RATE);
      end
      master.access(1'b0, 1'b1, 16'h1234, 32'h0000_0000, rd, ack);
      check(ack, 1'b1);
      check(rd, 32'h0000_0000);
      master.access(1'b1, 1'b0, IDX_SERVO_OFF_SEQ, 32'h0000_0001, rd, ack);
      for (int i = 1; i < 6; i++)
      begin
         rate_val[i] = 32'h0000_0001 + ($random(seed) & 32'h0000_00ff);
         master.access(1'b1, 1'b0, IDX_TAB[i], rate_val[i], rd, ack);
         master.access(1'b0, 1'b1, IDX_TAB[i], 32'h0000_0000, rd, ack);
         check(rd, rate_val[i]);
      end
      foreach (V_MODE[i])
         run_stop(V_MODE[i], V_CODE[i], 2'd0, 1'b1);
      foreach (X_MODE[i])
         run_stop(X_MODE[i], X_CODE[i], 2'd0, 1'b0);
      run_stop(MODE_PP, 16'h0000, 2'd0, 1'b1);
      run_stop(MODE_PV, 16'h0001, 2'd1, 1'b1);
      run_stop(MODE_HM, 16'h0001, 2'd1, 1'b1);
      run_stop(MODE_CST, 16'h0001, 2'd1, 1'b1);
      run_stop(MODE_PP, 16'h0001, 2'd2, 1'b1);
      end_sim;
   end

   // A hang is cut short well after the expected run of a few hundred cycles
   initial
   begin
      #500000;
      n_mismatch++;
      end_sim;
   end
endmodule
